// [rtl/pwm_evt_pkg.sv]
// Constants, register map and event carrier for the PWM event, brake and ADC trigger block.
// Assumes one clock domain and a plain register port with one-cycle read latency.
package pwm_evt_pkg;

    localparam int NUM_CH = 6;
    localparam int NUM_PAIR = 3;

    // ************************************************************
    // Register offsets.
    // ************************************************************
    localparam logic [7:0] OFS_COUNTER_EVENT_FLAGS = 8'hE8;
    localparam logic [7:0] OFS_BRAKE_FLAGS_AND_STATE = 8'hEC;
    localparam logic [7:0] OFS_ADC_TRIGGER_SELECT_LOW = 8'hF8;
    localparam logic [7:0] OFS_ADC_TRIGGER_SELECT_HIGH = 8'hFC;
    localparam logic [7:0] OFS_BRAKE_INTERRUPT_ENABLES = 8'hE4;
    localparam logic [7:0] OFS_SOFT_BRAKE = 8'hDC;
    localparam logic [7:0] OFS_ADC_TRIG_STATUS = 8'h20;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int POS_CMP_DOWN = 24;
    localparam int POS_CMP_UP = 16;
    localparam int POS_PERIOD = 8;
    localparam int POS_ZERO = 0;
    localparam int POS_LEVEL_STATE = 24;
    localparam int POS_EDGE_STATE = 16;
    localparam int POS_LEVEL_FLAG = 8;
    localparam int POS_EDGE_FLAG = 0;
    localparam int POS_LEVEL_IEN = 8;
    localparam int POS_EDGE_IEN = 0;
    localparam int POS_SOFT_LEVEL = 8;
    localparam int POS_SOFT_EDGE = 0;
    localparam int POS_ADC_STATUS = 16;
    localparam int POS_TRIG_EN = 7;
    localparam int SRC_W = 4;
    localparam int BYTE_W = 8;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [5:0] EVEN_MASK = 6'h15;

    // ************************************************************
    // ADC trigger source codes.
    // ************************************************************
    localparam logic [3:0] SRC_ZERO = 4'h0;
    localparam logic [3:0] SRC_PERIOD = 4'h1;
    localparam logic [3:0] SRC_ZERO_OR_PERIOD = 4'h2;
    localparam logic [3:0] SRC_EVEN_UP = 4'h3;
    localparam logic [3:0] SRC_EVEN_DOWN = 4'h4;
    localparam logic [3:0] SRC_ODD_UP = 4'h8;
    localparam logic [3:0] SRC_ODD_DOWN = 4'h9;

    // Counter events of all channels, one pulse per cycle each.
    typedef struct packed {
        logic [5:0] zero;
        logic [5:0] period;
        logic [5:0] cmp_up;
        logic [5:0] cmp_down;
        logic [5:0] period_end;
    } counter_events_s;

    // Brake events of all channels.
    typedef struct packed {
        logic [5:0] level_fall;
        logic [5:0] edge_fall;
        logic [5:0] level_src_high;
    } brake_events_s;

endpackage : pwm_evt_pkg

// [rtl/pwm_event_brake_adc_trigger.sv]
// Event flags, brake flags and state, and ADC trigger selection of a six-channel PWM unit.
// Assumes counter and brake events other than the level_src_high level come as one-cycle pulses from logic on ref_clk,
// and that the write protection unlock level is already synchronous to ref_clk.
`timescale 1ns/10ps

module pwm_event_brake_adc_trigger
    import pwm_evt_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic write_protect_unlock,
    input wire logic [2:0] complementary_mode,
    input counter_events_s cnt_evt,
    input brake_events_s brk_evt,
    output logic [5:0] adc_trig,
    output logic [2:0] level_brake_irq,
    output logic [2:0] edge_brake_irq,
    output logic [5:0] level_brake_out,
    output logic [5:0] edge_brake_out
);

    // ************************************************************
    // Elaboration check.
    // ************************************************************
    if (CHANNELS != NUM_CH) begin : g_chk
        $error("Only six channels are supported.");
    end
    if (NUM_PAIR * 2 != NUM_CH) begin : g_chk_pairs
        $error("Channels must come in pairs.");
    end
    if (POS_TRIG_EN >= BYTE_W || SRC_W > POS_TRIG_EN) begin : g_chk_field
        $error("Trigger enable must sit above the source field.");
    end

    logic [5:0] cmp_up_flag_q;
    logic [5:0] cmp_down_flag_q;
    logic [5:0] period_flag_q;
    logic [5:0] zero_flag_q;
    logic [5:0] level_brake_state_q;
    logic [5:0] edge_brake_state_q;
    logic [5:0] level_brake_flag_q;
    logic [5:0] edge_brake_flag_q;
    logic [5:0] adc_trig_status_q;
    logic [2:0] level_brake_irq_en_pair_q;
    logic [2:0] edge_brake_irq_en_pair_q;
    logic [31:0] adc_sel_low_q;
    logic [15:0] adc_sel_high_q;
    logic [47:0] adc_sel;
    logic [5:0] cmp_up_evt;
    logic [5:0] cmp_down_evt;
    logic [5:0] adc_pulse_d;
    logic [5:0] soft_level;
    logic [5:0] soft_edge;
    logic [5:0] level_set;
    logic [5:0] edge_set;
    logic wr_flags0;
    logic wr_flags1;
    logic wr_status;
    logic prot_ok;
    logic wr_enables;
    logic wr_soft;
    logic wr_sel_low;
    logic wr_sel_high;

    // Expands one bit per pair into one bit per channel.
    function automatic logic [5:0] pair_to_ch(input logic [2:0] p);
        pair_to_ch = {p[2], p[2], p[1], p[1], p[0], p[0]};
    endfunction : pair_to_ch

    // Reduces per-channel bits to one bit per pair.
    function automatic logic [2:0] ch_to_pair(input logic [5:0] c);
        ch_to_pair = {c[5] | c[4], c[3] | c[2], c[1] | c[0]};
    endfunction : ch_to_pair

    // Clears flags written with one and sets flags of new events; a set wins.
    function automatic logic [5:0] w1c_update(input logic [5:0] flags, input logic clr_en,
            input logic [5:0] clr_bits, input logic [5:0] set_bits);
        w1c_update = (flags & ~({NUM_CH{clr_en}} & clr_bits)) | set_bits;
    endfunction : w1c_update

    // Tells whether a strobe addresses the given register.
    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
            input logic [7:0] ofs);
        reg_hit = strobe && (addr == ofs);
    endfunction : reg_hit

    // ************************************************************
    // Write decode.
    // ************************************************************
    assign prot_ok = write_protect_unlock;
    assign wr_flags0 = reg_hit(reg_write, reg_addr, OFS_COUNTER_EVENT_FLAGS);
    assign wr_flags1 = reg_hit(reg_write, reg_addr, OFS_BRAKE_FLAGS_AND_STATE) && prot_ok;
    assign wr_status = reg_hit(reg_write, reg_addr, OFS_ADC_TRIG_STATUS);
    assign wr_enables = reg_hit(reg_write, reg_addr, OFS_BRAKE_INTERRUPT_ENABLES) && prot_ok;
    assign wr_soft = reg_hit(reg_write, reg_addr, OFS_SOFT_BRAKE) && prot_ok;
    assign wr_sel_low = reg_hit(reg_write, reg_addr, OFS_ADC_TRIGGER_SELECT_LOW);
    assign wr_sel_high = reg_hit(reg_write, reg_addr, OFS_ADC_TRIGGER_SELECT_HIGH);

    always_comb begin
        soft_level = '0;
        soft_edge = '0;
        if (wr_soft) begin
            soft_level = pair_to_ch(reg_wdata[POS_SOFT_LEVEL +: NUM_PAIR]);
            soft_edge = pair_to_ch(reg_wdata[POS_SOFT_EDGE +: NUM_PAIR]);
        end
    end

    assign level_set = brk_evt.level_fall | soft_level;
    assign edge_set = brk_evt.edge_fall | soft_edge;

    // ************************************************************
    // Complementary mode compare fold.
    // ************************************************************
    always_comb begin
        cmp_up_evt = cnt_evt.cmp_up;
        cmp_down_evt = cnt_evt.cmp_down;
        for (int p = 0; p < NUM_PAIR; p++) begin
            if (complementary_mode[p]) begin
                cmp_up_evt[2 * p] = cnt_evt.cmp_up[2 * p] | cnt_evt.cmp_up[2 * p + 1];
                cmp_down_evt[2 * p] = cnt_evt.cmp_down[2 * p] | cnt_evt.cmp_down[2 * p + 1];
            end
        end
    end

    // ************************************************************
    // Counter event flags.
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cmp_up_flag_q <= '0;
            cmp_down_flag_q <= '0;
        end else begin
            // Set wins over a clear in the same cycle.
            cmp_up_flag_q <= w1c_update(cmp_up_flag_q, wr_flags0,
                reg_wdata[POS_CMP_UP +: NUM_CH], cnt_evt.cmp_up);
            cmp_down_flag_q <= w1c_update(cmp_down_flag_q, wr_flags0,
                reg_wdata[POS_CMP_DOWN +: NUM_CH], cnt_evt.cmp_down);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            period_flag_q <= '0;
            zero_flag_q <= '0;
        end else begin
            period_flag_q <= w1c_update(period_flag_q, wr_flags0,
                reg_wdata[POS_PERIOD +: NUM_CH], cnt_evt.period) & EVEN_MASK;
            zero_flag_q <= w1c_update(zero_flag_q, wr_flags0,
                reg_wdata[POS_ZERO +: NUM_CH], cnt_evt.zero) & EVEN_MASK;
        end
    end

    // ************************************************************
    // Brake flags and enables.
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            level_brake_flag_q <= '0;
            edge_brake_flag_q <= '0;
        end else begin
            level_brake_flag_q <= w1c_update(level_brake_flag_q, wr_flags1,
                reg_wdata[POS_LEVEL_FLAG +: NUM_CH], level_set);
            edge_brake_flag_q <= w1c_update(edge_brake_flag_q, wr_flags1,
                reg_wdata[POS_EDGE_FLAG +: NUM_CH], edge_set);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            level_brake_irq_en_pair_q <= '0;
            edge_brake_irq_en_pair_q <= '0;
        end else if (wr_enables) begin
            level_brake_irq_en_pair_q <= reg_wdata[POS_LEVEL_IEN +: NUM_PAIR];
            edge_brake_irq_en_pair_q <= reg_wdata[POS_EDGE_IEN +: NUM_PAIR];
        end
    end

    // ************************************************************
    // Brake state.
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            level_brake_state_q <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (level_set[c]) begin
                    level_brake_state_q[c] <= 1'b1;
                end else if (brk_evt.level_src_high[c] && cnt_evt.period_end[c]) begin
                    level_brake_state_q[c] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            edge_brake_state_q <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (edge_set[c]) begin
                    edge_brake_state_q[c] <= 1'b1;
                end else if (!edge_brake_flag_q[c] && cnt_evt.period_end[c]) begin
                    edge_brake_state_q[c] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // ADC trigger selection.
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            adc_sel_low_q <= RESET_WORD;
        end else if (wr_sel_low) begin
            adc_sel_low_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            adc_sel_high_q <= RESET_WORD[15:0];
        end else if (wr_sel_high) begin
            adc_sel_high_q <= reg_wdata[15:0];
        end
    end

    assign adc_sel = {adc_sel_high_q, adc_sel_low_q};

    always_comb begin
        adc_pulse_d = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            logic [3:0] src;
            int e;
            src = adc_sel[c * BYTE_W +: SRC_W];
            e = (c / 2) * 2;
            if (adc_sel[c * BYTE_W + POS_TRIG_EN]) begin
                unique case (src)
                    SRC_ZERO: adc_pulse_d[c] = cnt_evt.zero[e];
                    SRC_PERIOD: adc_pulse_d[c] = cnt_evt.period[e];
                    SRC_ZERO_OR_PERIOD: adc_pulse_d[c] = cnt_evt.zero[e] | cnt_evt.period[e];
                    SRC_EVEN_UP: adc_pulse_d[c] = cnt_evt.cmp_up[e];
                    SRC_EVEN_DOWN: adc_pulse_d[c] = cnt_evt.cmp_down[e];
                    SRC_ODD_UP: adc_pulse_d[c] = cnt_evt.cmp_up[e + 1];
                    SRC_ODD_DOWN: adc_pulse_d[c] = cnt_evt.cmp_down[e + 1];
                    default: adc_pulse_d[c] = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            adc_trig <= '0;
        end else begin
            adc_trig <= adc_pulse_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            adc_trig_status_q <= '0;
        end else begin
            adc_trig_status_q <= w1c_update(adc_trig_status_q, wr_status,
                reg_wdata[POS_ADC_STATUS +: NUM_CH], adc_pulse_d);
        end
    end

    // ************************************************************
    // Interrupt requests and brake outputs.
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            level_brake_irq <= '0;
            edge_brake_irq <= '0;
        end else begin
            level_brake_irq <= ch_to_pair(level_brake_flag_q) & level_brake_irq_en_pair_q;
            edge_brake_irq <= ch_to_pair(edge_brake_flag_q) & edge_brake_irq_en_pair_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            level_brake_out <= '0;
            edge_brake_out <= '0;
        end else begin
            level_brake_out <= level_brake_state_q;
            edge_brake_out <= edge_brake_state_q;
        end
    end

    // ************************************************************
    // Read port.
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= RESET_WORD;
        end else if (reg_read) begin
            unique case (reg_addr)
                OFS_COUNTER_EVENT_FLAGS: reg_rdata <= {2'h0, cmp_down_flag_q, 2'h0,
                    cmp_up_flag_q, 2'h0, period_flag_q, 2'h0, zero_flag_q};
                OFS_BRAKE_FLAGS_AND_STATE: reg_rdata <= {2'h0, level_brake_state_q, 2'h0,
                    edge_brake_state_q, 2'h0, level_brake_flag_q, 2'h0, edge_brake_flag_q};
                OFS_BRAKE_INTERRUPT_ENABLES: reg_rdata <= {21'h0, level_brake_irq_en_pair_q,
                    5'h0, edge_brake_irq_en_pair_q};
                OFS_ADC_TRIGGER_SELECT_LOW: reg_rdata <= adc_sel_low_q;
                OFS_ADC_TRIGGER_SELECT_HIGH: reg_rdata <= {16'h0, adc_sel_high_q};
                OFS_ADC_TRIG_STATUS: reg_rdata <= {10'h0, adc_trig_status_q, 16'h0};
                default: reg_rdata <= RESET_WORD;
            endcase
        end else begin
            reg_rdata <= RESET_WORD;
        end
    end

endmodule : pwm_event_brake_adc_trigger

// [tb/evt_monitor.sv]
// Port checker of the PWM event, brake and ADC trigger block.
// Assumes it is bound to the block top and sees its ports.
`timescale 1ns/10ps
module evt_monitor
    import pwm_evt_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire counter_events_s cnt_evt,
    input wire brake_events_s brk_evt,
    input wire logic [5:0] adc_trig,
    input wire logic [2:0] level_brake_irq,
    input wire logic [2:0] edge_brake_irq,
    input wire logic [5:0] level_brake_out,
    input wire logic [5:0] edge_brake_out
);
    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_level_fall;
        brk_evt.level_fall != 6'h00;
    endsequence
    sequence s_edge_fall;
        brk_evt.edge_fall != 6'h00;
    endsequence
    a_level_set: assert property (s_level_fall |-> ##2
        (level_brake_out & $past(brk_evt.level_fall, 2)) == $past(brk_evt.level_fall, 2))
        else $error("level brake state missing after fall");
    a_edge_set: assert property (s_edge_fall |-> ##2
        (edge_brake_out & $past(brk_evt.edge_fall, 2)) == $past(brk_evt.edge_fall, 2))
        else $error("edge brake state missing after fall");
    a_level_release: assert property (($past(level_brake_out) & ~level_brake_out
        & ~$past(cnt_evt.period_end & brk_evt.level_src_high, 2)) == 6'h00)
        else $error("level brake released off period end");
    a_edge_release: assert property (($past(edge_brake_out) & ~edge_brake_out
        & ~$past(cnt_evt.period_end, 2)) == 6'h00)
        else $error("edge brake released off period end");
    a_trig_cause: assert property (adc_trig != 6'h00 |-> $past(cnt_evt[29:6]) != 24'h0)
        else $error("adc trigger without counter event");
    a_lirq_rise: assert property ((level_brake_irq & ~$past(level_brake_irq)) != 3'h0
        |-> $past(reg_write || brk_evt.level_fall != 6'h00, 2))
        else $error("level irq rose without cause");
    a_eirq_rise: assert property ((edge_brake_irq & ~$past(edge_brake_irq)) != 3'h0
        |-> $past(reg_write || brk_evt.edge_fall != 6'h00, 2))
        else $error("edge irq rose without cause");
    a_irq_fall: assert property (($past({level_brake_irq, edge_brake_irq})
        & ~{level_brake_irq, edge_brake_irq}) != 6'h00 |-> $past(reg_write, 2))
        else $error("brake irq fell without a write");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
endmodule : evt_monitor

bind pwm_event_brake_adc_trigger evt_monitor #(.CHANNELS(CHANNELS)) evt_monitor_inst (.*);

// [tb/far_side_model.sv]
// Model of the counter, brake sources and ADC start logic.
// Assumes the bench calls its tasks right after a clock edge.
`timescale 1ns/10ps
module far_side_model
    import pwm_evt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [5:0] adc_trig,
    output counter_events_s cnt_evt,
    output brake_events_s brk_evt,
    output logic [5:0] trig_seen
);
    // ************************************************************
    // Event pulses and trigger capture.
    // ************************************************************
    initial begin
        cnt_evt = '0;
        brk_evt = '0;
        trig_seen = 6'h00;
    end
    task automatic fire(input counter_events_s c, input logic [5:0] lf, input logic [5:0] ef);
        @(posedge ref_clk);
        cnt_evt <= c;
        brk_evt.level_fall <= lf;
        brk_evt.edge_fall <= ef;
        @(posedge ref_clk);
        cnt_evt <= '0;
        brk_evt.level_fall <= 6'h00;
        brk_evt.edge_fall <= 6'h00;
        #1 trig_seen = adc_trig;
    endtask : fire
    task automatic src(input logic [5:0] v);
        @(posedge ref_clk);
        brk_evt.level_src_high <= v;
    endtask : src
endmodule : far_side_model

// [tb/tb.sv]
// Self-checking bench of the PWM event, brake and ADC trigger block.
// Assumes the far side model drives all counter and brake events.
`timescale 1ns/10ps
module tb;
    import pwm_evt_pkg::*;
    logic ref_clk, reset_n, reg_write, reg_read, write_protect_unlock;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [2:0] complementary_mode, level_brake_irq, edge_brake_irq;
    logic [5:0] adc_trig, level_brake_out, edge_brake_out, trig_seen;
    logic [3:0] c;
    logic [29:0] ev;
    counter_events_s cnt_evt;
    brake_events_s brk_evt;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] regs [7] = '{8'hE8, 8'hEC, 8'hF8, 8'hFC, 8'hE4, 8'h20, 8'h00};
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'h5};

    pwm_event_brake_adc_trigger pwm_event_brake_adc_trigger_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .write_protect_unlock(write_protect_unlock), .complementary_mode(complementary_mode),
        .cnt_evt(cnt_evt), .brk_evt(brk_evt), .adc_trig(adc_trig),
        .level_brake_irq(level_brake_irq), .edge_brake_irq(edge_brake_irq),
        .level_brake_out(level_brake_out), .edge_brake_out(edge_brake_out));
    far_side_model far_side_model_inst (.ref_clk(ref_clk), .adc_trig(adc_trig),
        .cnt_evt(cnt_evt), .brk_evt(brk_evt), .trig_seen(trig_seen));

    // ************************************************************
    // Bus tasks, compare and closing report.
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk($sformatf("register %h", a), e, rv);
    endtask : chk_reg
    function automatic logic hit(input logic [3:0] s, input int kd, input logic odd);
        case (kd)
            0: return !odd && (s == 4'h0 || s == 4'h2);
            1: return !odd && (s == 4'h1 || s == 4'h2);
            2: return s == (odd ? 4'h8 : 4'h3);
            default: return s == (odd ? 4'h9 : 4'h4);
        endcase
    endfunction : hit
    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_sim();
        end
    end

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        reset_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        write_protect_unlock = 1'b0;
        complementary_mode = 3'h5;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (regs[i]) chk_reg(regs[i], 32'h0);
        wr(OFS_BRAKE_INTERRUPT_ENABLES, 32'hFFFF_FFFF);
        chk_reg(OFS_BRAKE_INTERRUPT_ENABLES, 32'h0);
        @(posedge ref_clk) write_protect_unlock <= 1'b1;
        wr(OFS_BRAKE_INTERRUPT_ENABLES, 32'hFFFF_FFFF);
        chk_reg(OFS_BRAKE_INTERRUPT_ENABLES, 32'h0000_0707);
        far_side_model_inst.fire({24'hFF_FFFF, 6'h00}, 6'h00, 6'h00);
        chk("adc trig", 32'h0, {26'h0, trig_seen});
        chk_reg(OFS_COUNTER_EVENT_FLAGS, 32'h3F3F_1515);
        wr(OFS_COUNTER_EVENT_FLAGS, 32'h0101_0101);
        chk_reg(OFS_COUNTER_EVENT_FLAGS, 32'h3E3E_1414);
        wr(OFS_COUNTER_EVENT_FLAGS, 32'hFFFF_FFFF);
        chk_reg(OFS_COUNTER_EVENT_FLAGS, 32'h0);
        foreach (codes[i]) begin
            c = codes[i];
            wr(OFS_ADC_TRIGGER_SELECT_LOW, {4'h0, c, 4'h8, c, 4'h0, c, 4'h8, c});
            wr(OFS_ADC_TRIGGER_SELECT_HIGH, {20'h0, c, 4'h8, c});
            for (int k = 0; k < 8; k++) begin
                ev = {24'h0, (k % 2 == 1) ? 6'h2A : 6'h15} << (24 - 6 * (k / 2));
                far_side_model_inst.fire(ev, 6'h00, 6'h00);
                chk("adc trig", hit(c, k / 2, k % 2 == 1) ? 32'h15 : 32'h0, {26'h0, trig_seen});
            end
        end
        chk_reg(OFS_ADC_TRIGGER_SELECT_LOW, 32'h0585_0585);
        chk_reg(OFS_ADC_TRIG_STATUS, 32'h0015_0000);
        wr(OFS_ADC_TRIG_STATUS, 32'hFFFF_FFFF);
        chk_reg(OFS_ADC_TRIG_STATUS, 32'h0);
        far_side_model_inst.fire('0, 6'h04, 6'h20);
        chk_reg(OFS_BRAKE_FLAGS_AND_STATE, 32'h0420_0420);
        chk("brake out", 32'h120, {20'h0, level_brake_out, edge_brake_out});
        chk("irq", 32'h14, {26'h0, level_brake_irq, edge_brake_irq});
        wr(OFS_BRAKE_INTERRUPT_ENABLES, 32'h0000_0005);
        repeat (2) @(negedge ref_clk);
        chk("irq", 32'h04, {26'h0, level_brake_irq, edge_brake_irq});
        far_side_model_inst.src(6'h04);
        far_side_model_inst.fire({24'h0, 6'h24}, 6'h00, 6'h00);
        chk_reg(OFS_BRAKE_FLAGS_AND_STATE, 32'h0020_0420);
        wr(OFS_BRAKE_FLAGS_AND_STATE, 32'h0000_0020);
        far_side_model_inst.fire({24'h0, 6'h20}, 6'h00, 6'h00);
        chk_reg(OFS_BRAKE_FLAGS_AND_STATE, 32'h0000_0400);
        @(posedge ref_clk) write_protect_unlock <= 1'b0;
        wr(OFS_BRAKE_FLAGS_AND_STATE, 32'hFFFF_FFFF);
        chk_reg(OFS_BRAKE_FLAGS_AND_STATE, 32'h0000_0400);
        @(posedge ref_clk) write_protect_unlock <= 1'b1;
        wr(OFS_BRAKE_FLAGS_AND_STATE, 32'h0000_0400);
        chk_reg(OFS_BRAKE_FLAGS_AND_STATE, 32'h0);
        chk("irq", 32'h0, {26'h0, level_brake_irq, edge_brake_irq});
        far_side_model_inst.src(6'h00);
        wr(OFS_SOFT_BRAKE, 32'h0000_0200);
        rd(OFS_BRAKE_FLAGS_AND_STATE);
        chk("soft brake", 32'h0400_0400, rv & 32'h0400_0400);
        end_sim();
    end
endmodule : tb
